// ### rtl/rbs_pkg.sv
// rbs_pkg: constants shared by the reset and brown-out sequencer files.
// assumes a single 20 MHz system clock that keeps running through all reset phases.
package rbs_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CLK_NS = 50;
   // slow oscillator period, ns
   localparam int SLOW_OSC_PERIOD_NS = 32_000;
   localparam int SLOW_OSC_DIV = (SLOW_OSC_PERIOD_NS + CLK_NS - 1) / CLK_NS;
   localparam int POWERUP_DELAY_TIMER_BITS = 11;
   localparam int POWERUP_DELAY_TIMER_PERIODS = 2048;
   localparam int OST_CYCLES = 1024;
   localparam int PLL_LOCK_MS = 2;
   localparam int PLL_LOCK_CYCLES = PLL_LOCK_MS * (CLK_HZ / 1000);
   // brown-out must persist this long before it resets, ns
   localparam int BOR_MIN_NS = 200;
   localparam int BOR_MIN_CYCLES = (BOR_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] BOR_MODE_OFF = 2'h0;
   localparam logic [1:0] BOR_MODE_SOFT = 2'h1;
   localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
   localparam logic [1:0] BOR_MODE_ON = 2'h3;
   localparam int SOFT_EN_BIT = 6;
   localparam logic SOFT_EN_RESET = 1'b1;
   localparam logic POR_FLAG_RESET = 1'b0;
   localparam logic BOR_FLAG_RESET = 1'b0;
   typedef enum logic [2:0] {
      RBS_ST_POR,
      RBS_ST_BROWN,
      RBS_ST_POWERUP_DELAY_TIMER,
      RBS_ST_OST,
      RBS_ST_PLL,
      RBS_ST_RUN
   } rbs_state_t;
endpackage

// ### rtl/rbs_tick_div.sv
// rbs_tick_div: divides the system clock into a one-cycle tick standing in for the slow osc.
// assumes CLK is the only clock; clr restarts the period from zero.
`timescale 1ns/10ps
`default_nettype none
module rbs_tick_div #(
   parameter int DIV = 640
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clr,
   output logic tick
);
   localparam int W = $clog2(DIV + 1);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   always_comb begin
      cnt_next = cnt_reg + W'(1);
      if (clr || cnt_reg == W'(DIV - 1)) begin
         cnt_next = '0;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   assign tick = !clr && cnt_reg == W'(DIV - 1);
endmodule // rbs_tick_div
`default_nettype wire

// ### rtl/rbs_filter.sv
// rbs_filter: declares a brown-out only after the comparator stays low for MIN cycles.
// assumes below is already synchronous; release is immediate once the supply recovers.
`timescale 1ns/10ps
`default_nettype none
module rbs_filter #(
   parameter int MIN = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic enable,
   input wire logic below,
   output logic brown
);
   localparam int W = $clog2(MIN + 1);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic brown_reg;
   logic brown_next;
   always_comb begin
      cnt_next = '0;
      brown_next = 1'b0;
      if (enable && below) begin
         // short dips under the minimum are ignored
         cnt_next = (cnt_reg == W'(MIN)) ? cnt_reg : cnt_reg + W'(1);
         brown_next = brown_reg || (cnt_reg + W'(1) >= W'(MIN));
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= '0;
         brown_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         brown_reg <= brown_next;
      end
   end
   assign brown = brown_reg;
endmodule // rbs_filter
`default_nettype wire

// ### rtl/rbs_sequencer.sv
// rbs_sequencer: power-on and brown-out reset sequencing with reset flags.
// assumes detector and fuse inputs are synchronous to CLK; the CPU writes flags by strobe.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - power-on pulse forces every phase back to the start and reset is held
// - power-on pulse clears the power-on flag; other resets leave it alone
// - only a software write sets the power-on flag to one again
// - nonzero enable mode: long enough drop below threshold resets device
// - reset is held while the supply stays below the threshold
// - with delay timer on, it starts after supply recovers and holds reset
// - dip during delay returns to brown-out and restarts the full delay
// - brown-out enable and delay timer enable are separate inputs
// - mode 01: soft enable bit turns the brown-out detector on or off
// - outside mode 01 the soft enable bit is ignored and reads zero
// - threshold selection comes only from the level fuse field
// - brown-out flag clears on every brown-out and power-on reset
// - mode 10: detector off in sleep, back on in other modes
// - mode 00: brown-out reset disabled and soft enable unavailable
// - mode 11: detector always on including sleep
// - delay timer counts 2048 slow oscillator periods of 32 us
// - reset held for the whole time the delay timer counts
// - active-low fuse bit enables the delay timer
// - crystal modes wait 1024 oscillator cycles after the delay
// - pll mode adds a 2 ms lock wait after the oscillator wait
// - timers run from power-on regardless of the external reset pin
module rbs_sequencer
   import rbs_pkg::*;
#(
   parameter int PLL_WAIT = PLL_LOCK_CYCLES,
   parameter int SLOW_DIV = SLOW_OSC_DIV,
   parameter int BOR_MIN = BOR_MIN_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic POR_PULSE,
   input wire logic SUPPLY_BELOW,
   input wire logic [1:0] BROWNOUT_ENABLE_MODE,
   input wire logic [1:0] BROWNOUT_LEVEL_SELECT,
   input wire logic POWERUP_TIMER_ENABLE_N,
   input wire logic OSC_CRYSTAL,
   input wire logic OSC_PLL,
   input wire logic OSC_TICK,
   input wire logic SLEEP_MODE,
   input wire logic EXTERNAL_RESET_PIN_N,
   input wire logic CTRL_WRITE,
   input wire logic [7:0] CTRL_WDATA,
   output logic CORE_RESET,
   output logic [1:0] BROWNOUT_THRESHOLD,
   output logic [7:0] RESET_CONTROL_REG,
   output logic BROWNOUT_ACTIVE
);
   localparam int PLL_W = $clog2(PLL_WAIT + 1);
   localparam int OST_W = $clog2(OST_CYCLES + 1);
   rbs_state_t state_reg, state_next;
   logic [POWERUP_DELAY_TIMER_BITS-1:0] powerup_delay_timer_reg, powerup_delay_timer_next;
   logic [OST_W-1:0] ost_reg, ost_next;
   logic [PLL_W-1:0] pll_reg, pll_next;
   logic soft_en_reg, soft_en_next;
   logic por_flag_reg, por_flag_next;
   logic bor_flag_reg, bor_flag_next;
   logic core_reset_reg, core_reset_next;
   logic [7:0] rcr_reg, rcr_next;
   logic [1:0] level_reg;
   logic det_en_reg, det_en_next;
   logic det_en;
   logic brown;
   logic slow_tick;
   logic powerup_delay_timer_clr;

   // detector enable per mode; fuse decides, software only in the soft mode
   always_comb begin
      det_en = 1'b0;
      if (BROWNOUT_ENABLE_MODE == BOR_MODE_SOFT) begin
         det_en = soft_en_reg;
      end else if (BROWNOUT_ENABLE_MODE == BOR_MODE_NOSLEEP) begin
         det_en = !SLEEP_MODE;
      end else if (BROWNOUT_ENABLE_MODE == BOR_MODE_ON) begin
         det_en = 1'b1;
      end else begin
         det_en = 1'b0;
      end
   end

   rbs_filter #(.MIN(BOR_MIN)) u_filter (
      .clk(CLK),
      .rst(RST || POR_PULSE),
      .enable(det_en),
      .below(SUPPLY_BELOW),
      .brown(brown)
   );

   assign powerup_delay_timer_clr = state_reg != RBS_ST_POWERUP_DELAY_TIMER;
   rbs_tick_div #(.DIV(SLOW_DIV)) u_slow (
      .clk(CLK),
      .rst(RST),
      .clr(powerup_delay_timer_clr),
      .tick(slow_tick)
   );

   // phase sequence; the external pin takes no part, so timers expire without it
   always_comb begin
      state_next = state_reg;
      powerup_delay_timer_next = powerup_delay_timer_reg;
      ost_next = ost_reg;
      pll_next = pll_reg;
      case (state_reg)
         RBS_ST_POR: begin
            powerup_delay_timer_next = '0;
            ost_next = '0;
            pll_next = '0;
            if (!POR_PULSE) begin
               state_next = RBS_ST_BROWN;
            end
         end
         RBS_ST_BROWN: begin
            powerup_delay_timer_next = '0;
            if (!(det_en && SUPPLY_BELOW)) begin
               if (!POWERUP_TIMER_ENABLE_N) begin
                  state_next = RBS_ST_POWERUP_DELAY_TIMER;
               end else if (OSC_CRYSTAL || OSC_PLL) begin
                  state_next = RBS_ST_OST;
               end else begin
                  state_next = RBS_ST_RUN;
               end
            end
         end
         RBS_ST_POWERUP_DELAY_TIMER: begin
            if (slow_tick) begin
               powerup_delay_timer_next = powerup_delay_timer_reg + POWERUP_DELAY_TIMER_BITS'(1);
               if (powerup_delay_timer_reg == POWERUP_DELAY_TIMER_BITS'(POWERUP_DELAY_TIMER_PERIODS - 1)) begin
                  state_next = (OSC_CRYSTAL || OSC_PLL) ? RBS_ST_OST : RBS_ST_RUN;
               end
            end
         end
         RBS_ST_OST: begin
            if (OSC_TICK) begin
               ost_next = ost_reg + OST_W'(1);
               if (ost_reg == OST_W'(OST_CYCLES - 1)) begin
                  state_next = OSC_PLL ? RBS_ST_PLL : RBS_ST_RUN;
               end
            end
         end
         RBS_ST_PLL: begin
            pll_next = pll_reg + PLL_W'(1);
            if (pll_reg == PLL_W'(PLL_WAIT - 1)) begin
               state_next = RBS_ST_RUN;
            end
         end
         default: begin
            state_next = RBS_ST_RUN;
         end
      endcase
      // brown-out overrides any later phase and restarts the chain
      if (brown && state_reg != RBS_ST_POR) begin
         state_next = RBS_ST_BROWN;
         powerup_delay_timer_next = '0;
         ost_next = '0;
         pll_next = '0;
      end
      if (POR_PULSE) begin
         state_next = RBS_ST_POR;
      end
      core_reset_next = state_next != RBS_ST_RUN;
   end

   // flags; a hardware clear wins over a software write in the same cycle
   always_comb begin
      soft_en_next = soft_en_reg;
      por_flag_next = por_flag_reg;
      bor_flag_next = bor_flag_reg;
      if (CTRL_WRITE) begin
         if (BROWNOUT_ENABLE_MODE == BOR_MODE_SOFT) begin
            soft_en_next = CTRL_WDATA[SOFT_EN_BIT];
         end
         por_flag_next = CTRL_WDATA[1];
         bor_flag_next = CTRL_WDATA[0];
      end
      if (brown) begin
         bor_flag_next = BOR_FLAG_RESET;
      end
      if (POR_PULSE) begin
         por_flag_next = POR_FLAG_RESET;
         bor_flag_next = BOR_FLAG_RESET;
         soft_en_next = SOFT_EN_RESET;
      end
      det_en_next = det_en;
      // soft enable only visible in the soft mode
      rcr_next = {1'b0,
         soft_en_next && BROWNOUT_ENABLE_MODE == BOR_MODE_SOFT,
         4'h0, por_flag_next, bor_flag_next};
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= RBS_ST_POR;
         powerup_delay_timer_reg <= '0;
         ost_reg <= '0;
         pll_reg <= '0;
         soft_en_reg <= SOFT_EN_RESET;
         por_flag_reg <= POR_FLAG_RESET;
         bor_flag_reg <= BOR_FLAG_RESET;
         core_reset_reg <= 1'b1;
         level_reg <= 2'h0;
         det_en_reg <= 1'b0;
         rcr_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         powerup_delay_timer_reg <= powerup_delay_timer_next;
         ost_reg <= ost_next;
         pll_reg <= pll_next;
         soft_en_reg <= soft_en_next;
         por_flag_reg <= por_flag_next;
         bor_flag_reg <= bor_flag_next;
         core_reset_reg <= core_reset_next;
         level_reg <= BROWNOUT_LEVEL_SELECT;
         det_en_reg <= det_en_next;
         rcr_reg <= rcr_next;
      end
   end

   assign CORE_RESET = core_reset_reg;
   assign BROWNOUT_THRESHOLD = level_reg;
   assign BROWNOUT_ACTIVE = det_en_reg;
   // registered view; the mode gate lags a mode change by one cycle
   assign RESET_CONTROL_REG = rcr_reg;
   // pin level is intentionally unused: sequencing runs from the pulse alone
   logic unused_pin;
   assign unused_pin = EXTERNAL_RESET_PIN_N;
endmodule // rbs_sequencer
`default_nettype wire

// ### bench/rbs_assertions.sv
// rbs_assertions: port-level properties of the reset sequencer.
// assumes bound onto rbs_sequencer; one clock, reset high.
`timescale 1ns/10ps
`default_nettype none
module rbs_assertions
   import rbs_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic POR_PULSE,
   input wire logic SUPPLY_BELOW,
   input wire logic [1:0] BROWNOUT_ENABLE_MODE,
   input wire logic [1:0] BROWNOUT_LEVEL_SELECT,
   input wire logic SLEEP_MODE,
   input wire logic CTRL_WRITE,
   input wire logic [7:0] CTRL_WDATA,
   input wire logic CORE_RESET,
   input wire logic [1:0] BROWNOUT_THRESHOLD,
   input wire logic [7:0] RESET_CONTROL_REG,
   input wire logic BROWNOUT_ACTIVE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // long enough to clear any filter latency
   sequence below_run;
      (SUPPLY_BELOW && BROWNOUT_ACTIVE)[*8];
   endsequence
   sequence soft_quiet;
      (BROWNOUT_ENABLE_MODE == BOR_MODE_SOFT && !CTRL_WRITE)[*3];
   endsequence
   por_hold_a: assert property (POR_PULSE |=> CORE_RESET)
      else $error("core left running during power-on pulse");
   por_clear_a: assert property (POR_PULSE |=> !RESET_CONTROL_REG[1])
      else $error("power-on flag not cleared");
   por_set_a: assert property ($rose(RESET_CONTROL_REG[1]) |->
      $past(CTRL_WRITE && CTRL_WDATA[1])) else $error("power-on flag set by hardware");
   brown_hold_a: assert property (below_run |->
      CORE_RESET && !RESET_CONTROL_REG[0]) else $error("brown-out not holding reset");
   soft_gate_a: assert property (soft_quiet |->
      BROWNOUT_ACTIVE == RESET_CONTROL_REG[6]) else $error("soft enable not gating");
   soft_zero_a: assert property (BROWNOUT_ENABLE_MODE != BOR_MODE_SOFT |=>
      !RESET_CONTROL_REG[6]) else $error("soft enable visible outside soft mode");
   level_copy_a: assert property (1'b1 |=>
      BROWNOUT_THRESHOLD == $past(BROWNOUT_LEVEL_SELECT)) else $error("threshold mismatch");
   sleep_gate_a: assert property (BROWNOUT_ENABLE_MODE == BOR_MODE_NOSLEEP |=>
      BROWNOUT_ACTIVE == !$past(SLEEP_MODE)) else $error("sleep gating wrong");
   mode_off_a: assert property (BROWNOUT_ENABLE_MODE == BOR_MODE_OFF |=>
      !BROWNOUT_ACTIVE) else $error("detector on in off mode");
   mode_on_a: assert property (BROWNOUT_ENABLE_MODE == BOR_MODE_ON |=>
      BROWNOUT_ACTIVE) else $error("detector off in always mode");
endmodule // rbs_assertions
bind rbs_sequencer rbs_assertions u_chk (.CLK, .RST, .POR_PULSE, .SUPPLY_BELOW,
   .BROWNOUT_ENABLE_MODE, .BROWNOUT_LEVEL_SELECT, .SLEEP_MODE, .CTRL_WRITE, .CTRL_WDATA,
   .CORE_RESET, .BROWNOUT_THRESHOLD, .RESET_CONTROL_REG, .BROWNOUT_ACTIVE);
`default_nettype wire

// ### bench/rbs_supply_model.sv
// rbs_supply_model: supply detectors and crystal seen by the sequencer.
// assumes bench commands change just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module rbs_supply_model (
   input wire logic clk,
   input wire logic por_cmd,
   input wire logic dip_cmd,
   output logic por_pulse,
   output logic below,
   output logic osc_tick
);
   // crystal at half the system clock keeps the osc wait short
   logic ph = 1'b0;
   always @(posedge clk) ph <= ~ph;
   assign osc_tick = ph;
   assign por_pulse = por_cmd;
   // supply is also low while the power-on pulse stands
   assign below = dip_cmd | por_cmd;
endmodule // rbs_supply_model
`default_nettype wire

// ### bench/test_reset_brownout_sequencer.sv
// test_reset_brownout_sequencer: self-checking bench for rbs_sequencer.
// assumes short divider and pll parameters; model ticks osc every 2nd cycle.
`timescale 1ns/10ps
`default_nettype none
module test_reset_brownout_sequencer;
   import rbs_pkg::*;
   localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_PERIODS * 2;
   localparam int OST_CYC = OST_CYCLES * 2;
   logic clk, rst, por_cmd, dip_cmd, powerup_delay_timer_n, xtal, pll, sleep, ext_n, wr;
   logic [1:0] mode, lvl;
   logic [7:0] wd;
   wire logic por, below, tick, core_rst, active;
   wire logic [1:0] thr;
   wire logic [7:0] rcr;
   int n_fail, checks_done;
   rbs_supply_model u_sup (.clk(clk), .por_cmd(por_cmd), .dip_cmd(dip_cmd),
      .por_pulse(por), .below(below), .osc_tick(tick));
   rbs_sequencer #(.PLL_WAIT(10), .SLOW_DIV(2), .BOR_MIN(4)) uut (.CLK(clk), .RST(rst),
      .POR_PULSE(por), .SUPPLY_BELOW(below), .BROWNOUT_ENABLE_MODE(mode),
      .BROWNOUT_LEVEL_SELECT(lvl), .POWERUP_TIMER_ENABLE_N(powerup_delay_timer_n), .OSC_CRYSTAL(xtal),
      .OSC_PLL(pll), .OSC_TICK(tick), .SLEEP_MODE(sleep), .EXTERNAL_RESET_PIN_N(ext_n),
      .CTRL_WRITE(wr), .CTRL_WDATA(wd), .CORE_RESET(core_rst), .BROWNOUT_THRESHOLD(thr),
      .RESET_CONTROL_REG(rcr), .BROWNOUT_ACTIVE(active));
   task automatic check(input string what, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic set_flags(input logic [7:0] d);
      wr = 1;
      wd = d;
      cyc(1);
      wr = 0;
      cyc(1);
   endtask
   // cycles until the core is let go, bounded
   task automatic run_len(output int n);
      n = 0;
      while (core_rst !== 1'b0 && n < 20000) begin
         cyc(1);
         n++;
      end
   endtask
   task automatic power_up(input logic pn, x, p, input int exp);
      int n;
      powerup_delay_timer_n = pn;
      xtal = x;
      pll = p;
      por_cmd = 1;
      cyc(3);
      check("reset in pulse", core_rst, 1);
      check("por flag", rcr[1], 0);
      por_cmd = 0;
      run_len(n);
      check("release time", n >= exp && n <= exp + 8, 1);
   endtask
   task automatic t_powerup;
      power_up(0, 1, 0, POWERUP_DELAY_TIMER_CYC + OST_CYC);
      check("reg after power-on", rcr, 8'h40);
      ext_n = 0;
      power_up(1, 1, 1, OST_CYC + 10);
      ext_n = 1;
      power_up(1, 0, 0, 0);
   endtask
   task automatic t_flags;
      set_flags(8'h43);
      check("reg soft", rcr, 8'h43);
      mode = BOR_MODE_ON;
      set_flags(8'h43);
      check("reg on", rcr, 8'h03);
      power_up(1, 0, 0, 0);
      check("flags after pulse", rcr[1:0], 2'b00);
   endtask
   task automatic t_brown;
      int n;
      powerup_delay_timer_n = 0;
      set_flags(8'h03);
      dip_cmd = 1;
      cyc(20);
      check("reset in dip", core_rst, 1);
      check("flags after dip", rcr[1:0], 2'b10);
      dip_cmd = 0;
      cyc(1000);
      dip_cmd = 1;
      cyc(10);
      dip_cmd = 0;
      run_len(n);
      check("restart delay", n >= POWERUP_DELAY_TIMER_CYC && n <= POWERUP_DELAY_TIMER_CYC + 8, 1);
      powerup_delay_timer_n = 1;
   endtask
   task automatic try_dip(input logic [1:0] m, input logic s, sl, exp);
      int n;
      mode = m;
      lvl = ~m;
      sleep = sl;
      set_flags({1'b0, s, 6'h03});
      check("threshold", thr, 2'(~m));
      dip_cmd = 1;
      cyc(20);
      check("dip reset", core_rst, exp);
      check("bor flag", rcr[0], !exp);
      dip_cmd = 0;
      run_len(n);
      check("quick release", n <= 8, 1);
      sleep = 0;
   endtask
   task automatic t_modes;
      try_dip(BOR_MODE_OFF, 1, 0, 0);
      try_dip(BOR_MODE_SOFT, 0, 0, 0);
      try_dip(BOR_MODE_SOFT, 1, 0, 1);
      try_dip(BOR_MODE_NOSLEEP, 0, 1, 0);
      try_dip(BOR_MODE_NOSLEEP, 0, 0, 1);
      try_dip(BOR_MODE_ON, 0, 1, 1);
   endtask
   task automatic finish_test;
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial begin
      {rst, por_cmd, dip_cmd, powerup_delay_timer_n, xtal, pll, sleep, ext_n, wr} = 9'h182;
      wd = 8'h00;
      mode = BOR_MODE_SOFT;
      lvl = 2'h0;
      n_fail = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      #1 rst = 0;
      t_powerup;
      t_flags;
      t_brown;
      t_modes;
      finish_test;
   end
   // all scenarios need well under 20k cycles
   initial begin
      cyc(40000);
      n_fail++;
      finish_test;
   end
endmodule // test_reset_brownout_sequencer
`default_nettype wire
